// File: pkg/adc_out_pkg.sv
// Constants, field layouts and carriers for the dual converter output formatter.
// Summary of operation
// - Two 11-bit channels plus shared output clock.
// - Format from config bit or serial_enable pin.
// - Parallel format: one pin per bit, every cycle.
// - Separate data and clock drive boost settings.
// - DDR format: two bits per pair per cycle.
// - Odd bits on rising edge, even on falling.
// - Buffer current 3.5 default, 2.5, 4.5, 1.75 mA.
// - Current doubling bit for data and clock.
// - Three independent termination enables, any combination.
// - Latency 14 cycles, or 10 in low latency.
// - Multiplex only parallel: B interleaved, A high-impedance.
// - Two's complement or straight binary coding.
package adc_out_pkg;

  localparam int unsigned SAMPLE_W   = 11;
  localparam int unsigned PAIRS      = 6;
  localparam int unsigned LAT_NORMAL = 14;
  localparam int unsigned LAT_LOW    = 10;
  localparam int unsigned LAT_W      = 4;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // Control field positions.
  localparam int unsigned F_IFACE_DDR   = 0;
  localparam int unsigned F_PIN_MODE    = 1;
  localparam int unsigned F_FMT_BINARY  = 2;
  localparam int unsigned F_MUX         = 3;
  localparam int unsigned F_LOW_LAT     = 4;
  localparam int unsigned F_DATA_BOOST  = 5;
  localparam int unsigned F_CLOCK_BOOST = 6;
  localparam int unsigned F_CUR_DOUBLE  = 7;
  localparam int unsigned F_CUR_LO      = 8;
  localparam int unsigned F_TERM_LO     = 12;

  localparam logic [1:0] CUR_3P5 = 2'h0;
  localparam logic [1:0] CUR_2P5 = 2'h1;
  localparam logic [1:0] CUR_4P5 = 2'h2;
  localparam logic [1:0] CUR_1P75 = 2'h3;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] term;
    logic [1:0] current;
    logic       cur_double;
    logic       clock_boost;
    logic       data_boost;
    logic       low_lat;
    logic       mux;
    logic       fmt_binary;
    logic       pin_mode;
    logic       iface_ddr;
  } cfg_s;

  typedef struct packed {
    logic [SAMPLE_W-1:0] a;
    logic [SAMPLE_W-1:0] b;
  } sample_pair_s;

endpackage

// File: verilog/adc_out_if.sv
// Output formatter: sample pipeline, parallel or DDR pins, and configuration registers.
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dual_adc_output_interface (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [31:0]                         s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [31:0]                         s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  input  wire logic                                serial_enable,
  input  wire adc_out_pkg::sample_pair_s           core_sample,
  input  wire logic                                sample_clk,
  input  wire logic                                sample_rst_n,
  output logic                                     output_clock,
  output logic                                     output_clock_pos,
  output logic [adc_out_pkg::SAMPLE_W-1:0]         chan_a_bus,
  output logic [adc_out_pkg::SAMPLE_W-1:0]         chan_a_oe,
  output logic [adc_out_pkg::SAMPLE_W-1:0]         chan_b_bus,
  output logic [adc_out_pkg::SAMPLE_W-1:0]         chan_b_oe,
  output logic [adc_out_pkg::PAIRS-1:0]            ddr_a_pair,
  output logic [adc_out_pkg::PAIRS-1:0]            ddr_b_pair,
  output logic                                     data_drive_boost,
  output logic                                     clock_drive_boost,
  output logic [1:0]                               buffer_current,
  output logic                                     current_double,
  output logic [2:0]                               termination
);

  localparam int unsigned W = adc_out_pkg::SAMPLE_W;
  localparam int unsigned D = adc_out_pkg::LAT_NORMAL;

  // Bus-side state.
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    adc_out_pkg::cfg_s cfg;
    logic [1:0]  pin_sync;
    logic [1:0]  ddr_sync;
    logic [1:0]  pin_meta;
  } bus_state_s;

  bus_state_s st;
  bus_state_s next_st;

  logic [31:0] ctrl_word;
  logic        eff_ddr;
  logic        eff_binary;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[adc_out_pkg::F_IFACE_DDR]   = st.cfg.iface_ddr;
    ctrl_word[adc_out_pkg::F_PIN_MODE]    = st.cfg.pin_mode;
    ctrl_word[adc_out_pkg::F_FMT_BINARY]  = st.cfg.fmt_binary;
    ctrl_word[adc_out_pkg::F_MUX]         = st.cfg.mux;
    ctrl_word[adc_out_pkg::F_LOW_LAT]     = st.cfg.low_lat;
    ctrl_word[adc_out_pkg::F_DATA_BOOST]  = st.cfg.data_boost;
    ctrl_word[adc_out_pkg::F_CLOCK_BOOST] = st.cfg.clock_boost;
    ctrl_word[adc_out_pkg::F_CUR_DOUBLE]  = st.cfg.cur_double;
    ctrl_word[adc_out_pkg::F_CUR_LO +: 2] = st.cfg.current;
    ctrl_word[adc_out_pkg::F_TERM_LO +: 3] = st.cfg.term;
  end

  // In pin mode serial_enable steers both the interface and the coding.
  assign eff_ddr    = st.cfg.pin_mode ? st.pin_sync[1] : st.cfg.iface_ddr;
  assign eff_binary = st.cfg.pin_mode ? st.pin_sync[1] : st.cfg.fmt_binary;

  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready  = !st.w_got && !st.bvalid;
  assign s_axi_arready = !st.rvalid;

  always_comb begin
    next_st = st;
    next_st.pin_meta = {st.pin_meta[0], serial_enable};
    next_st.pin_sync = st.pin_meta;
    next_st.ddr_sync = {st.ddr_sync[0], eff_ddr};
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = adc_out_pkg::RESP_OKAY;
      if (st.awaddr == adc_out_pkg::ADDR_CTRL) begin
        if (st.wdata[adc_out_pkg::F_IFACE_DDR])
          next_st.cfg.mux = 1'b0;
        next_st.cfg.iface_ddr   = st.wdata[adc_out_pkg::F_IFACE_DDR];
        next_st.cfg.pin_mode    = st.wdata[adc_out_pkg::F_PIN_MODE];
        next_st.cfg.fmt_binary  = st.wdata[adc_out_pkg::F_FMT_BINARY];
        // Mux cannot be set together with DDR; the write leaves it clear.
        next_st.cfg.mux = st.wdata[adc_out_pkg::F_MUX]
                          && !st.wdata[adc_out_pkg::F_IFACE_DDR];
        next_st.cfg.low_lat     = st.wdata[adc_out_pkg::F_LOW_LAT];
        next_st.cfg.data_boost  = st.wdata[adc_out_pkg::F_DATA_BOOST];
        next_st.cfg.clock_boost = st.wdata[adc_out_pkg::F_CLOCK_BOOST];
        next_st.cfg.cur_double  = st.wdata[adc_out_pkg::F_CUR_DOUBLE];
        next_st.cfg.current     = st.wdata[adc_out_pkg::F_CUR_LO +: 2];
        next_st.cfg.term        = st.wdata[adc_out_pkg::F_TERM_LO +: 3];
      end else if (st.awaddr != adc_out_pkg::ADDR_STATUS) begin
        next_st.bresp = adc_out_pkg::RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = adc_out_pkg::RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        adc_out_pkg::ADDR_CTRL:   next_st.rdata = ctrl_word;
        adc_out_pkg::ADDR_STATUS: next_st.rdata = {29'h0000_0000, st.pin_sync[1],
                                                   eff_binary, eff_ddr};
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = adc_out_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (!aresetn) begin
      next_st = '0;
      // Each field is taken from its own bit of the reset word, so the layouts may differ.
      next_st.cfg.iface_ddr   = adc_out_pkg::CTRL_RESET[adc_out_pkg::F_IFACE_DDR];
      next_st.cfg.pin_mode    = adc_out_pkg::CTRL_RESET[adc_out_pkg::F_PIN_MODE];
      next_st.cfg.fmt_binary  = adc_out_pkg::CTRL_RESET[adc_out_pkg::F_FMT_BINARY];
      next_st.cfg.mux         = adc_out_pkg::CTRL_RESET[adc_out_pkg::F_MUX];
      next_st.cfg.low_lat     = adc_out_pkg::CTRL_RESET[adc_out_pkg::F_LOW_LAT];
      next_st.cfg.data_boost  = adc_out_pkg::CTRL_RESET[adc_out_pkg::F_DATA_BOOST];
      next_st.cfg.clock_boost = adc_out_pkg::CTRL_RESET[adc_out_pkg::F_CLOCK_BOOST];
      next_st.cfg.cur_double  = adc_out_pkg::CTRL_RESET[adc_out_pkg::F_CUR_DOUBLE];
      next_st.cfg.current     = adc_out_pkg::CTRL_RESET[adc_out_pkg::F_CUR_LO +: 2];
      next_st.cfg.term        = adc_out_pkg::CTRL_RESET[adc_out_pkg::F_TERM_LO +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp  = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp  = st.rresp;
  assign s_axi_rdata  = st.rdata;

  // Electrical settings leave as levels; the pad ring reads them directly.
  assign data_drive_boost  = st.cfg.data_boost;
  assign clock_drive_boost = st.cfg.clock_boost;
  assign buffer_current    = st.cfg.current;
  assign current_double    = st.cfg.cur_double;
  assign termination       = st.cfg.term;

  // Sample-clock domain. Mode bits are quasi-static, so a four-flop level crossing (two _m, two _s) is enough.
  typedef struct packed {
    logic [1:0]                  ddr_m;
    logic [1:0]                  ddr_s;
    logic [1:0]                  bin_m;
    logic [1:0]                  bin_s;
    logic [1:0]                  mux_m;
    logic [1:0]                  mux_s;
    logic [1:0]                  lat_m;
    logic [1:0]                  lat_s;
    logic [D-1:0][2*W-1:0]       pipe;
    logic                        phase;
    logic [W-1:0]                a_out;
    logic [W-1:0]                b_out;
    logic                        a_en;
  } link_state_s;

  link_state_s ls;
  link_state_s next_ls;
  logic [2*W-1:0] tap;
  logic [2*W-1:0] coded;

  always_comb begin
    coded = {core_sample.a, core_sample.b};
    if (ls.bin_s[1]) begin
      coded[2*W-1] = ~coded[2*W-1];
      coded[W-1]   = ~coded[W-1];
    end
  end

  // Low latency taps earlier in the same delay line.
  assign tap = ls.lat_s[1] ? ls.pipe[adc_out_pkg::LAT_LOW-1] : ls.pipe[D-1];

  always_comb begin
    next_ls = ls;
    // The effective choice is carried over, so pin mode can also select the paired format.
    next_ls.ddr_m = {ls.ddr_m[0], eff_ddr};
    next_ls.ddr_s = {ls.ddr_s[0], ls.ddr_m[1]};
    next_ls.bin_m = {ls.bin_m[0], eff_binary};
    next_ls.bin_s = {ls.bin_s[0], ls.bin_m[1]};
    next_ls.mux_m = {ls.mux_m[0], st.cfg.mux};
    next_ls.mux_s = {ls.mux_s[0], ls.mux_m[1]};
    next_ls.lat_m = {ls.lat_m[0], st.cfg.low_lat};
    next_ls.lat_s = {ls.lat_s[0], ls.lat_m[1]};
    next_ls.pipe  = {ls.pipe[D-2:0], coded};
    next_ls.phase = ~ls.phase;
    next_ls.a_en  = !ls.mux_s[1];
    next_ls.a_out = tap[2*W-1 -: W];
    // Multiplexed mode alternates A then B on the B bus.
    if (ls.mux_s[1] && !ls.ddr_s[1])
      next_ls.b_out = ls.phase ? tap[W-1:0] : tap[2*W-1 -: W];
    else
      next_ls.b_out = tap[W-1:0];
    if (!sample_rst_n)
      next_ls = '0;
  end

  always_ff @(posedge sample_clk) begin
    ls <= next_ls;
  end

  logic ddr_live;
  assign ddr_live = ls.ddr_s[1];

  // Parallel pins, each bit on its own driver.
  assign chan_a_bus = ls.a_out;
  assign chan_b_bus = ls.b_out;
  assign chan_a_oe  = {W{!ddr_live && ls.a_en}};
  assign chan_b_oe  = {W{!ddr_live}};

  // output_clock is the sample clock passed through ungated; output_clock_pos is gated to 0 outside the DDR format.
  assign output_clock     = sample_clk;
  assign output_clock_pos = ddr_live ? sample_clk : 1'b0;

  // DDR: high half of the cycle carries odd bits, low half even bits.
  genvar p;
  generate
    for (p = 0; p < adc_out_pkg::PAIRS; p++) begin : g_pair
      logic odd_a;
      logic odd_b;
      if (2*p+1 < W) begin : g_odd
        assign odd_a = ls.a_out[2*p+1];
        assign odd_b = ls.b_out[2*p+1];
      end else begin : g_top
        assign odd_a = 1'b0;
        assign odd_b = 1'b0;
      end
      assign ddr_a_pair[p] = !ddr_live ? 1'b0 : sample_clk ? odd_a : ls.a_out[2*p];
      assign ddr_b_pair[p] = !ddr_live ? 1'b0 : sample_clk ? odd_b : ls.b_out[2*p];
    end
  endgenerate

endmodule // dual_adc_output_interface

// File: test/adc_out_monitor.sv
// Concurrent checks on the formatter's pin behaviour and configuration levels.
`timescale 1ns/1ps
module adc_out_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        sample_clk,
  input wire logic        sample_rst_n,
  input wire logic        output_clock_pos,
  input wire logic [10:0] chan_a_oe,
  input wire logic [10:0] chan_b_oe,
  input wire logic [5:0]  ddr_a_pair,
  input wire logic [5:0]  ddr_b_pair,
  input wire logic        data_drive_boost,
  input wire logic        clock_drive_boost,
  input wire logic [1:0]  buffer_current,
  input wire logic        current_double,
  input wire logic [2:0]  termination
);
  logic [31:0] last_ctrl;
  logic        ctrl_take;
  assign ctrl_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     && s_axi_awaddr == 32'h0;
  // A copy of the last control word lets every level check name its exact source bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) last_ctrl <= 32'h0;
    else if (ctrl_take) last_ctrl <= s_axi_wdata;
  end
  sequence ctrl_written;
    ctrl_take ##1 1'h1;
  endsequence
  a_data_boost: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_written |-> ##[0:7] data_drive_boost == last_ctrl[5]) else $error("data boost stale.");
  a_clock_boost: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_written |-> ##[0:7] clock_drive_boost == last_ctrl[6]) else $error("clock boost stale.");
  a_current_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_written |-> ##[0:7] buffer_current == last_ctrl[9:8]) else $error("current stale.");
  a_current_dbl: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_written |-> ##[0:7] current_double == last_ctrl[7]) else $error("doubling stale.");
  a_term_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_written |-> ##[0:7] termination == last_ctrl[14:12]) else $error("termination stale.");
  a_pairs_quiet: assert property (@(negedge sample_clk) disable iff (!sample_rst_n)
    !output_clock_pos |-> ddr_a_pair == 6'h0 && ddr_b_pair == 6'h0) else $error("pairs busy.");
  a_top_slot: assert property (@(negedge sample_clk) disable iff (!sample_rst_n)
    output_clock_pos |-> !ddr_a_pair[5] && !ddr_b_pair[5]) else $error("top slot not zero.");
  a_oe_whole: assert property (@(posedge sample_clk) disable iff (!sample_rst_n)
    chan_a_oe inside {11'h0, 11'h7ff} && chan_b_oe inside {11'h0, 11'h7ff})
    else $error("partial enable.");
endmodule // adc_out_monitor

// File: test/adc_capture_model.sv
// Receiving logic that rebuilds sample words from either pin format.
`timescale 1ns/1ps
module adc_capture_model #(
  parameter int SETTLE_NS = 12
) (
  input wire logic                  output_clock,
  input wire logic                  output_clock_pos,
  input wire logic [10:0]           chan_a_bus,
  input wire logic [10:0]           chan_b_bus,
  input wire logic [5:0]            ddr_a_pair,
  input wire logic [5:0]            ddr_b_pair,
  output adc_out_pkg::sample_pair_s par,
  output adc_out_pkg::sample_pair_s ddr
);
  logic [11:0] wa, wb;
  logic [5:0]  odd_a, odd_b;
  always @(posedge output_clock) par <= {chan_a_bus, chan_b_bus};
  // Sampling mid-phase stands in for the receiver's setup and hold window.
  always @(posedge output_clock_pos) begin
    #SETTLE_NS;
    odd_a = ddr_a_pair;
    odd_b = ddr_b_pair;
  end
  always @(negedge output_clock_pos) begin
    #SETTLE_NS;
    for (int p = 0; p < 6; p++) begin
      wa[2*p] = ddr_a_pair[p];
      wa[2*p+1] = odd_a[p];
      wb[2*p] = ddr_b_pair[p];
      wb[2*p+1] = odd_b[p];
    end
    ddr = {wa[10:0], wb[10:0]};
  end
endmodule // adc_capture_model

// File: test/dual_adc_output_interface_tb.sv
// Self-checking bench for the dual converter output formatter.
`timescale 1ns/1ps
module dual_adc_output_interface_tb;
  logic        aclk = 1'h0, aresetn = 1'h0, sample_clk = 1'h0, sample_rst_n = 1'h0;
  logic        serial_enable = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, buffer_current, r;
  logic        output_clock, output_clock_pos, data_drive_boost, clock_drive_boost;
  logic [10:0] chan_a_bus, chan_a_oe, chan_b_bus, chan_b_oe;
  logic [5:0]  ddr_a_pair, ddr_b_pair;
  logic        current_double, chk_on = 1'h0, mode_ddr, mode_bin, pin;
  logic [2:0]  termination;
  logic [31:0] q, d, mode_tab [5] = '{32'h0, 32'h14, 32'h11, 32'h2, 32'h7};
  adc_out_pkg::sample_pair_s core_sample = '0, cap_par, cap_ddr, e, hist [64];
  int unsigned ecount = 0, cycles = 0, lag = 16, bad_count = 0, n_compared = 0;
  dual_adc_output_interface dual_adc_output_interface_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_enable, .core_sample,
    .sample_clk, .sample_rst_n, .output_clock, .output_clock_pos, .chan_a_bus, .chan_a_oe,
    .chan_b_bus, .chan_b_oe, .ddr_a_pair, .ddr_b_pair, .data_drive_boost, .clock_drive_boost,
    .buffer_current, .current_double, .termination);
  adc_capture_model adc_capture_model_inst (.output_clock, .output_clock_pos, .chan_a_bus,
    .chan_b_bus, .ddr_a_pair, .ddr_b_pair, .par(cap_par), .ddr(cap_ddr));
  initial forever #20 aclk = ~aclk;
  initial begin
    #7;
    forever #24 sample_clk = ~sample_clk;
  end
  function automatic adc_out_pkg::sample_pair_s fmtp(adc_out_pkg::sample_pair_s s, logic bin);
    fmtp = s;
    fmtp.a[10] = s.a[10] ^ bin;
    fmtp.b[10] = s.b[10] ^ bin;
  endfunction
  function automatic logic [31:0] levels();
    return {17'h0, termination, 2'h0, buffer_current, current_double, clock_drive_boost,
            data_drive_boost, 5'h0};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    aw = 0;
    w = 0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready && !aw) s_axi_awvalid <= 1'h0;
      if (s_axi_wready && !w) s_axi_wvalid <= 1'h0;
      aw = aw || s_axi_awready;
      w = w || s_axi_wready;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sample_clk) begin
    hist[ecount[5:0]] = core_sample;
    ecount++;
    core_sample <= 22'($urandom);
  end
  always @(negedge sample_clk) begin
    if (chk_on) begin
      e = fmtp(hist[6'(ecount - lag)], mode_bin);
      if (mode_ddr) check(32'(cap_ddr), 32'(e));
      else begin
        check(32'(cap_par), 32'(e));
        check({10'h0, chan_a_oe, chan_b_oe}, 32'h3f_ffff);
        e = fmtp(hist[6'(ecount - lag + 1)], mode_bin);
        check(32'({chan_a_bus, chan_b_bus}), 32'(e));
      end
    end
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h4357));
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    sample_rst_n <= 1'h1;
    rd(32'h0, q, r);
    check(q, adc_out_pkg::CTRL_RESET);
    check(levels(), 32'h0);
    for (int i = 0; i < 5; i++) begin
      serial_enable <= 1'(i == 3);
      wr(32'h0, mode_tab[i], r);
      repeat (60) @(posedge aclk);
      pin = mode_tab[i][1];
      mode_ddr = pin ? 1'(i == 3) : mode_tab[i][0];
      mode_bin = pin ? 1'(i == 3) : mode_tab[i][2];
      lag = mode_tab[i][4] ? 12 : 16;
      rd(32'h4, q, r);
      check(q, {29'h0, 1'(i == 3), mode_bin, mode_ddr});
      chk_on = 1'h1;
      repeat (30) @(posedge aclk);
      chk_on = 1'h0;
      $display("format test %0d done", i);
    end
    wr(32'h0, 32'h8, r);
    repeat (60) @(posedge aclk);
    check({chan_a_oe, chan_b_oe}, 32'h7ff);
    wr(32'h0, 32'h9, r);
    rd(32'h0, q, r);
    check(q, 32'h1);
    $display("multiplex test done");
    for (int i = 0; i < 8; i++) begin
      d = ($urandom & 32'he0) | (32'(i) << 12) | (32'(i & 3) << 8);
      wr(32'h0, d, r);
      check(32'(r), 32'(adc_out_pkg::RESP_OKAY));
      rd(32'h0, q, r);
      check(q, d);
      check(levels(), d);
    end
    $display("settings test done");
    rd(32'h8, q, r);
    check(q, 32'h0);
    check(32'(r), 32'(adc_out_pkg::RESP_SLVERR));
    wr(32'h4, 32'hffff_ffff, r);
    rd(32'h0, q, r);
    check(q, d);
    $display("bus test done");
    wrap_up();
  end
endmodule // dual_adc_output_interface_tb
bind dual_adc_output_interface adc_out_monitor adc_out_monitor_inst (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .sample_clk, .sample_rst_n, .output_clock_pos, .chan_a_oe, .chan_b_oe, .ddr_a_pair,
  .ddr_b_pair, .data_drive_boost, .clock_drive_boost, .buffer_current, .current_double,
  .termination);
